// file: pkg/charger_protect_regs.vh
`ifndef CHARGER_PROTECT_REGS_VH
`define CHARGER_PROTECT_REGS_VH
// register locations
`define ADDR_TIMER_TS_CONTROL  8'h05
`define ADDR_OVP_DETECT_CTRL   8'h06
// timer and thermistor control fields
`define BIT_TIMER_STRETCH      7
`define BIT_TIMER_LIMIT_HI     6
`define BIT_TIMER_LIMIT_LO     5
`define BIT_BATT_DISCONNECT    4
`define BIT_THERM_ENABLE       3
`define RST_TIMER_TS_CONTROL   8'hA8
// overvoltage and detection fields
`define BIT_OVP_HI             7
`define BIT_OVP_LO             5
`define BIT_RELEASE_DPLUS      4
`define BIT_FORCE_BATTERY_DETECT       3
`define BIT_FORCE_PTEST        2
`define RST_OVP_DETECT_CTRL    8'hE0
// thermistor status codes
`define THERM_NO_FAULT         3'h0
`define THERM_OPEN_OFF         3'h7
// timer base tick: 1 ms at 20 MHz
`define CLK_FREQ_HZ            20000000
`define TICK_TIME_US           1000
`define TICK_CYCLES            ((`CLK_FREQ_HZ / 1000000) * `TICK_TIME_US)
`endif

// file: design/timer_rate_gen.v
`timescale 1ns/1ps
`include "charger_protect_regs.vh"
module timer_rate_gen #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_stretch,
  output reg  o_tick
);
  reg [15:0] count_reg;
  reg        half_reg;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= 16'h0000;
      half_reg  <= 1'b0;
      o_tick    <= 1'b0;
    end else if (count_reg == TICK_CYCLES[15:0] - 16'h0001) begin
      count_reg <= 16'h0000;
      // phase restarts while not stretched, so a stretched tick is always two periods on
      half_reg  <= i_stretch & ~half_reg;
      o_tick    <= ~i_stretch | half_reg;
    end else begin
      count_reg <= count_reg + 16'h0001;
      o_tick    <= 1'b0;
    end
  end
endmodule // timer_rate_gen

// file: design/thermistor_status.v
`timescale 1ns/1ps
`include "charger_protect_regs.vh"
module thermistor_status (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire       i_enable,
  input  wire [2:0] i_fault_code,
  output reg  [2:0] o_status
);
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_status <= `THERM_OPEN_OFF;
    end else if (!i_enable) begin
      o_status <= `THERM_OPEN_OFF;
    end else begin
      o_status <= i_fault_code;
    end
  end
endmodule // thermistor_status

// file: design/charger_protect_config_regs.v
`timescale 1ns/1ps
`include "charger_protect_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// - with stretch on the safety timer runs at half rate during any current-reducing loop.
// - with stretch disabled the safety timer always runs at its normal rate.
// - with disconnect enabled the battery switch opens on loss of input, never otherwise.
// - thermistor monitoring is active only while the thermistor enable bit is set.
// - the thermistor condition is reported in a read-only status field.
// - bits 7 to 5 of location 06 select the input overvoltage threshold code.
// - the D+ source stays on during dead battery charging unless the release bit is set.
// - battery detection runs when forced, on termination, or while production test mode is on.
// - the force detect bit reads back whether a battery is present.
// - setting the test force bit enters production test mode with input current limit off.
// - production test mode is refused while a battery is present.
// - location 06 resets to E0.
// - location 05 holds stretch enable bit 7, disconnect bit 4, thermistor enable bit 3.
// - the thermistor status uses bits 2 to 0 with 111 meaning open or disabled.
module charger_protect_config_regs (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire       i_wr_en,
  input  wire       i_rd_en,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_loop_active,
  input  wire       i_input_present,
  input  wire       i_dead_battery_charging,
  input  wire       i_termination,
  input  wire       i_battery_present,
  input  wire [2:0] i_therm_fault_code,
  output reg  [7:0] o_rdata,
  output reg        o_timer_tick,
  output reg        o_battery_switch_off,
  output reg        o_thermistor_monitor_on,
  output reg  [2:0] o_input_overvoltage_select,
  output reg        o_dplus_source_on,
  output reg        o_battery_detect_run,
  output reg        o_production_test_mode,
  output reg        o_input_current_limit_off
);
  // stored registers and their next values
  reg  [7:0] timer_ts_reg;
  reg  [7:0] timer_ts_next;
  reg  [7:0] ovp_reg;
  reg  [7:0] ovp_next;
  reg        ptest_reg;
  reg        ptest_next;
  reg  [7:0] rdata_next;

  // next values of the registered outputs
  reg        switch_off_next;
  reg        detect_run_next;
  reg  [2:0] ovp_select_next;
  reg        dplus_on_next;
  reg        therm_on_next;
  reg        ptest_mode_next;
  reg        ilim_off_next;

  // decode of the current access
  wire       wr_timer_ts;
  wire       wr_ovp;
  wire       rd_timer_ts;
  wire       rd_ovp;
  wire       rd_unmapped;

  // fields of the stored registers
  wire       stretch_bit;
  wire       disconnect_bit;
  wire       therm_enable_bit;
  wire [2:0] ovp_code;
  wire       release_bit;
  wire       force_detect_bit;
  wire       ptest_req;
  wire       ptest_allowed;

  // links to the sub-blocks
  wire       stretch_now;
  wire       tick;
  wire [2:0] therm_status;

  //////////////////////////////////////////////////////////////////////////////
  // helper functions
  // exact match of a bus location
  function addr_hit;
    input [7:0] a;
    input [7:0] b;
    begin
      addr_hit = (a == b);
    end
  endfunction

  // timer and thermistor control: bits 2 to 0 are status and never stored
  function [7:0] timer_ts_writable;
    input [7:0] v;
    begin
      timer_ts_writable = {v[7:3], 3'h0};
    end
  endfunction

  // overvoltage control: the two unused low bits are never stored
  function [7:0] ovp_writable;
    input [7:0] v;
    begin
      ovp_writable = {v[7:2], 2'h0};
    end
  endfunction

  // read word of the timer and thermistor control location
  function [7:0] timer_ts_word;
    input [7:0] stored;
    input [2:0] status;
    begin
      timer_ts_word = {stored[7:3], status};
    end
  endfunction

  // read word of the overvoltage location, bit 3 shows the battery live
  function [7:0] ovp_word;
    input [7:0] stored;
    input       present;
    begin
      ovp_word = {stored[7:4], present, stored[2:0]};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // access decode and field taps
  assign wr_timer_ts      = i_wr_en & addr_hit(i_addr, `ADDR_TIMER_TS_CONTROL);
  assign wr_ovp           = i_wr_en & addr_hit(i_addr, `ADDR_OVP_DETECT_CTRL);
  assign rd_timer_ts      = i_rd_en & addr_hit(i_addr, `ADDR_TIMER_TS_CONTROL);
  assign rd_ovp           = i_rd_en & addr_hit(i_addr, `ADDR_OVP_DETECT_CTRL);
  assign rd_unmapped      = i_rd_en & ~rd_timer_ts & ~rd_ovp;
  assign stretch_bit      = timer_ts_reg[`BIT_TIMER_STRETCH];
  assign disconnect_bit   = timer_ts_reg[`BIT_BATT_DISCONNECT];
  assign therm_enable_bit = timer_ts_reg[`BIT_THERM_ENABLE];
  assign ovp_code         = ovp_reg[`BIT_OVP_HI:`BIT_OVP_LO];
  assign release_bit      = ovp_reg[`BIT_RELEASE_DPLUS];
  assign force_detect_bit = ovp_reg[`BIT_FORCE_BATTERY_DETECT];
  assign ptest_req        = ovp_reg[`BIT_FORCE_PTEST];

  //////////////////////////////////////////////////////////////////////////////
  // register next values
  always @* begin
    timer_ts_next = timer_ts_reg;
    if (wr_timer_ts) begin
      timer_ts_next = timer_ts_writable(i_wdata);
    end
  end

  always @* begin
    ovp_next = ovp_reg;
    if (wr_ovp) begin
      ovp_next = ovp_writable(i_wdata);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // stored registers
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      timer_ts_reg <= `RST_TIMER_TS_CONTROL;
    end else begin
      timer_ts_reg <= timer_ts_next;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ovp_reg <= `RST_OVP_DETECT_CTRL;
    end else begin
      ovp_reg <= ovp_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // production test entry
  // refuse with battery
  assign ptest_allowed = ~i_battery_present;

  // a request made with a battery fitted waits and enters once the battery is gone
  always @* begin
    ptest_next = ptest_reg;
    if (!ptest_req) begin
      ptest_next = 1'b0;
    end else if (!ptest_reg && ptest_allowed) begin
      ptest_next = 1'b1;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptest_reg <= 1'b0;
    end else begin
      ptest_reg <= ptest_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // safety timer rate
  // stretch during loops
  assign stretch_now = stretch_bit & i_loop_active;

  timer_rate_gen u_rate (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_stretch (stretch_now),
    .o_tick    (tick)
  );

  thermistor_status u_therm (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_enable     (therm_enable_bit),
    .i_fault_code (i_therm_fault_code),
    .o_status     (therm_status)
  );

  //////////////////////////////////////////////////////////////////////////////
  // control output next values
  // battery side
  always @* begin
    if (disconnect_bit && !i_input_present) begin
      switch_off_next = 1'b1;
    end else begin
      switch_off_next = 1'b0;
    end
    detect_run_next = force_detect_bit | i_termination | ptest_reg;
  end

  // input side
  always @* begin
    ovp_select_next = ovp_code;
    if (i_dead_battery_charging && !release_bit) begin
      dplus_on_next = 1'b1;
    end else begin
      dplus_on_next = 1'b0;
    end
  end

  // thermistor and test mode
  always @* begin
    therm_on_next   = therm_enable_bit;
    ptest_mode_next = ptest_reg;
    ilim_off_next   = ptest_reg;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered control outputs
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_timer_tick               <= 1'b0;
      o_battery_switch_off       <= 1'b0;
      o_thermistor_monitor_on    <= 1'b0;
      o_input_overvoltage_select <= 3'h7;
      o_dplus_source_on          <= 1'b0;
      o_battery_detect_run       <= 1'b0;
      o_production_test_mode     <= 1'b0;
      o_input_current_limit_off  <= 1'b0;
    end else begin
      o_timer_tick               <= tick;
      o_battery_switch_off       <= switch_off_next;
      o_thermistor_monitor_on    <= therm_on_next;
      o_input_overvoltage_select <= ovp_select_next;
      o_dplus_source_on          <= dplus_on_next;
      o_battery_detect_run       <= detect_run_next;
      o_production_test_mode     <= ptest_mode_next;
      o_input_current_limit_off  <= ilim_off_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read back
  always @* begin
    rdata_next = o_rdata;
    if (rd_timer_ts) begin
      rdata_next = timer_ts_word(timer_ts_reg, therm_status);
    end else if (rd_ovp) begin
      rdata_next = ovp_word(ovp_reg, i_battery_present);
    end else if (rd_unmapped) begin
      rdata_next = 8'h00;
    end
  end

  // the read word stands until the next read
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rdata_next;
    end
  end
endmodule // charger_protect_config_regs

// file: dv/charger_host_model.sv
`timescale 1ns/1ps
module charger_host_model (
  input  wire       i_clk,
  input  wire [7:0] i_rdata,
  output reg        o_wr_en = 1'b0,
  output reg        o_rd_en = 1'b0,
  output reg  [7:0] o_addr = 8'h00,
  output reg  [7:0] o_wdata = 8'h00
);
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= (a == 8'h06) ? {v[7:2], 2'h0} : v;
      o_wr_en <= 1'b1;
      @(posedge i_clk);
      o_wr_en <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(posedge i_clk);
      o_addr <= a;
      o_rd_en <= 1'b1;
      @(posedge i_clk);
      o_rd_en <= 1'b0;
      @(posedge i_clk);
      #1 v = i_rdata;
    end
  endtask
endmodule // charger_host_model

// file: dv/charger_protect_sva.sv
`timescale 1ns/1ps
module charger_protect_sva (
  input wire       i_clk,
  input wire       i_rst_n,
  input wire       i_wr_en,
  input wire       i_rd_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       i_input_present,
  input wire       i_dead_battery_charging,
  input wire       i_termination,
  input wire       i_battery_present,
  input wire [7:0] o_rdata,
  input wire       o_timer_tick,
  input wire       o_battery_switch_off,
  input wire [2:0] o_input_overvoltage_select,
  input wire       o_dplus_source_on,
  input wire       o_battery_detect_run,
  input wire       o_production_test_mode,
  input wire       o_input_current_limit_off
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_wr_ovp;
    i_wr_en && i_addr == 8'h06;
  endsequence
  sequence s_rd_ovp;
    i_rd_en && i_addr == 8'h06;
  endsequence
  chk_ovp_select_follow: assert property (
    s_wr_ovp |-> ##2 o_input_overvoltage_select == $past(i_wdata[7:5], 2)) else $error("ovp");
  chk_ilim_with_test: assert property (
    o_input_current_limit_off == o_production_test_mode) else $error("ilim");
  chk_test_refused: assert property (
    (i_battery_present && !o_production_test_mode)[*3] |=> !o_production_test_mode)
    else $error("test mode");
  chk_detect_on_term: assert property (
    i_termination[*3] |-> o_battery_detect_run) else $error("detect");
  chk_switch_needs_loss: assert property (
    i_input_present[*3] |-> !o_battery_switch_off) else $error("switch");
  chk_dplus_needs_dbp: assert property (
    (!i_dead_battery_charging)[*3] |-> !o_dplus_source_on) else $error("dplus");
  chk_read_batt_live: assert property (
    s_rd_ovp |=> o_rdata[3] == $past(i_battery_present) && o_rdata[1:0] == 2'h0)
    else $error("batt");
  chk_tick_single: assert property (
    o_timer_tick |=> (!o_timer_tick)[*8]) else $error("tick");
endmodule // charger_protect_sva
bind charger_protect_config_regs charger_protect_sva charger_protect_sva_inst (.*);

// file: dv/charger_protect_config_regs_tb.sv
`timescale 1ns/1ps
module charger_protect_config_regs_tb;
  reg        i_clk = 0, i_rst_n = 0, i_loop_active = 0, i_input_present = 1;
  reg        i_dead_battery_charging = 1, i_termination = 0, i_battery_present = 1;
  reg  [2:0] i_therm_fault_code = 3'h4;
  wire       i_wr_en, i_rd_en, o_timer_tick, o_battery_switch_off, o_thermistor_monitor_on;
  wire       o_dplus_source_on, o_battery_detect_run, o_production_test_mode;
  wire       o_input_current_limit_off;
  wire [7:0] i_addr, i_wdata, o_rdata;
  wire [2:0] o_input_overvoltage_select;
  reg  [7:0] d;
  integer    err_total = 0, tests_run = 0, k, n;
  initial forever #25 i_clk = ~i_clk;
  charger_host_model charger_host_model_inst (.i_clk(i_clk), .i_rdata(o_rdata),
    .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wdata(i_wdata));
  charger_protect_config_regs charger_protect_config_regs_inst (
    .i_clk                      (i_clk),
    .i_rst_n                    (i_rst_n),
    .i_wr_en                    (i_wr_en),
    .i_rd_en                    (i_rd_en),
    .i_addr                     (i_addr),
    .i_wdata                    (i_wdata),
    .i_loop_active              (i_loop_active),
    .i_input_present            (i_input_present),
    .i_dead_battery_charging    (i_dead_battery_charging),
    .i_termination              (i_termination),
    .i_battery_present          (i_battery_present),
    .i_therm_fault_code         (i_therm_fault_code),
    .o_rdata                    (o_rdata),
    .o_timer_tick               (o_timer_tick),
    .o_battery_switch_off       (o_battery_switch_off),
    .o_thermistor_monitor_on    (o_thermistor_monitor_on),
    .o_input_overvoltage_select (o_input_overvoltage_select),
    .o_dplus_source_on          (o_dplus_source_on),
    .o_battery_detect_run       (o_battery_detect_run),
    .o_production_test_mode     (o_production_test_mode),
    .o_input_current_limit_off  (o_input_current_limit_off)
  );
  task chk(input [31:0] g, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task cyc(input integer c);
    begin
      repeat (c) @(posedge i_clk);
      #1;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      charger_host_model_inst.rd(a, d);
      chk(d, e);
    end
  endtask
  task wrc(input [7:0] a, input [7:0] v);
    begin
      charger_host_model_inst.wr(a, v);
      cyc(3);
    end
  endtask
  task gap(input integer lo, input integer hi);
    begin
      n = 0;
      do begin
        cyc(1);
        n = n + 1;
      end while (o_timer_tick !== 1'b1 && n < 50000);
      chk(n >= lo && n <= hi, 1);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    repeat (90000) @(posedge i_clk);
    err_total = err_total + 1;
    finish_test;
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    cyc(2);
    rdc(8'h05, 8'hAC);
    @(posedge i_clk) i_therm_fault_code <= 3'h5;
    rdc(8'h05, 8'hAD);
    rdc(8'h06, 8'hE8);
    chk({o_input_overvoltage_select, o_thermistor_monitor_on, o_dplus_source_on}, 5'h1F);
    for (k = 0; k < 8; k = k + 1) begin
      wrc(8'h06, k << 5);
      chk(o_input_overvoltage_select, k);
      rdc(8'h06, (k << 5) | 8'h08);
    end
    wrc(8'h06, 8'h13);
    rdc(8'h06, 8'h18);
    chk(o_dplus_source_on, 0);
    wrc(8'h05, 8'h10);
    rdc(8'h05, 8'h17);
    chk(o_thermistor_monitor_on, 0);
    @(posedge i_clk) i_input_present <= 1'b0;
    cyc(3);
    chk(o_battery_switch_off, 1);
    @(posedge i_clk) i_input_present <= 1'b1;
    i_dead_battery_charging <= 1'b0;
    wrc(8'h06, 8'h04);
    chk(o_production_test_mode, 0);
    @(posedge i_clk) i_battery_present <= 1'b0;
    cyc(4);
    chk({o_production_test_mode, o_input_current_limit_off, o_battery_detect_run}, 7);
    rdc(8'h06, 8'h04);
    wrc(8'h06, 8'h00);
    chk(o_battery_detect_run, 0);
    @(posedge i_clk) i_termination <= 1'b1;
    cyc(3);
    chk(o_battery_detect_run, 1);
    @(posedge i_clk) i_termination <= 1'b0;
    wrc(8'h06, 8'h08);
    chk(o_battery_detect_run, 1);
    rdc(8'h20, 8'h00);
    wrc(8'h05, 8'h80);
    @(posedge o_timer_tick);
    @(posedge i_clk) i_loop_active <= 1'b1;
    gap(39990, 40000);
    wrc(8'h05, 8'h00);
    gap(19980, 20000);
    finish_test;
  end
endmodule // charger_protect_config_regs_tb
